// ### design/ssl_regs.svh
// constants for the spindle speed lock control block
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

// =====================================================
// timing
`define SSL_CLK_MHZ        250
`define SSL_SLOW_US        10600
`define SSL_STOP_US        100000
`define SSL_LOCK_MS        1300
`define SSL_REF_GAP_NS     40
`define SSL_SLOW_CYC       (`SSL_SLOW_US * `SSL_CLK_MHZ)
`define SSL_STOP_CYC       (`SSL_STOP_US * `SSL_CLK_MHZ)
`define SSL_LOCK_CYC       (`SSL_LOCK_MS * `SSL_CLK_MHZ * 1000)
`define SSL_REF_GAP_CYC    ((`SSL_REF_GAP_NS * `SSL_CLK_MHZ + 999) / 1000)
`define SSL_GAP_W          25
`define SSL_LOCK_W         29

// =====================================================
// current command codes
`define SSL_CMD_FULL       8'hff
`define SSL_CMD_BRAKE      8'h4c
`define SSL_CMD_ZERO       8'h00

// =====================================================
// control register (write port 0) fields
`define SSL_CTL_RUN        0
`define SSL_CTL_ENABLE_N   1
`define SSL_CTL_SUBST      2
`define SSL_CTL_SUBST_A    3
`define SSL_CTL_SUBST_B    4
`define SSL_CTL_RESET      8'h02
// clear register (write port 1) field
`define SSL_CLR_LOST       0

// =====================================================
// synchronised pin vector positions
`define SSL_PIN_REF        0
`define SSL_PIN_ENC_A      1
`define SSL_PIN_ENC_B      2
`define SSL_PIN_CUR_LO     3
`define SSL_PIN_CUR_HI     6
`define SSL_PIN_W          7

// =====================================================
// divide-by-three and lock counting
`define SSL_DIV_LAST       2'h2
`define SSL_ENC_PER_REF    2'h2
`define SSL_ENC_SAT        2'h3

`endif

// ### design/ssl_pkg.sv
// types for the spindle speed lock control block
package ssl_pkg;

    // =====================================================
    // drive modes
    typedef enum logic [1:0] {
        SSL_IDLE,
        SSL_RUN,
        SSL_BRAKE,
        SSL_COAST
    } ssl_mode_t;

endpackage : ssl_pkg

// ### design/ssl_sync3.sv
// three-stage pin synchroniser with agreement filter
module ssl_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pinIn,
    output      logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] s1Q;
    logic [WIDTH-1:0] s2Q;
    logic [WIDTH-1:0] s3Q;

    // =====================================================
    // per-bit chain; stage 1 feeds only stage 2
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge mclk) begin
            if (rst) begin
                s1Q[i]     <= 1'b0;
                s2Q[i]     <= 1'b0;
                s3Q[i]     <= 1'b0;
                syncOut[i] <= 1'b0;
            end else begin
                s1Q[i] <= pinIn[i];
                s2Q[i] <= s1Q[i];
                s3Q[i] <= s2Q[i];
                if (s2Q[i] == s3Q[i]) begin
                    syncOut[i] <= s3Q[i];
                end
            end
        end
    end

endmodule : ssl_sync3

// ### design/ssl_phase_det.sv
// tri-state phase/frequency detector
module ssl_phase_det (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic refPulse,
    input  wire logic encPulse,
    output      logic phaseErr,
    output      logic slowDown
);

    logic upD;
    logic dnD;

    always_comb begin
        upD = phaseErr | refPulse;
        dnD = slowDown | encPulse;
        // both set means the edges met: cancel
        if (upD && dnD) begin
            upD = 1'b0;
            dnD = 1'b0;
        end
    end

    // =====================================================
    // up/down state
    always_ff @(posedge mclk) begin
        if (rst) begin
            phaseErr <= 1'b0;
            slowDown <= 1'b0;
        end else begin
            phaseErr <= upD;
            slowDown <= dnD;
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_PFD_UP: assert property (refPulse && !encPulse && !slowDown |=> phaseErr)
        else $error("reference pulse did not raise detector");
    AST_PFD_DOWN: assert property (encPulse && !refPulse |=> !phaseErr)
        else $error("encoder pulse did not lower detector");
    AST_PFD_EXCL: assert property (!(phaseErr && slowDown))
        else $error("detector up and down both active");
    COV_PFD_PULSE: cover property (refPulse ##1 phaseErr [*3] ##1 encPulse ##1 !phaseErr);

endmodule : ssl_phase_det

// ### design/ssl_speed_lock.sv
// spindle speed lock control: pulse generators, detector, limiter, status
`include "ssl_regs.svh"

module ssl_speed_lock
    import ssl_pkg::*;
#(
    parameter logic [`SSL_GAP_W-1:0]  SLOW_CYC = `SSL_GAP_W'(`SSL_SLOW_CYC),
    parameter logic [`SSL_GAP_W-1:0]  STOP_CYC = `SSL_GAP_W'(`SSL_STOP_CYC),
    parameter logic [`SSL_LOCK_W-1:0] LOCK_CYC = `SSL_LOCK_W'(`SSL_LOCK_CYC)
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       refSquareWave,
    input  wire logic       encoderA,
    input  wire logic       encoderB,
    input  wire logic [3:0] currentDetect,
    input  wire logic       ctrlWrEn,
    input  wire logic       clrWrEn,
    input  wire logic [7:0] wrData,
    output      logic [7:0] statusReg0,
    output      logic [7:0] statusReg1,
    output      logic [7:0] statusReg2,
    output      logic [7:0] statusReg3,
    output      logic       atSpeedN,
    output      logic       rotatingFlag,
    output      logic       lostLockFlag,
    output      logic       thirdRateLimitTick,
    output      logic       dutyLimit,
    output      logic       ampEnableN,
    output      logic [7:0] currentCmdPos,
    output      logic [7:0] currentCmdNeg
);

    localparam int REF_GAP = `SSL_REF_GAP_CYC;

    logic [`SSL_PIN_W-1:0]  pinSync;
    logic [7:0]             ctrlQ;
    logic                   refPrevQ;
    logic                   refRise;
    logic                   refPulseQ;
    logic [7:0]             refGapQ;
    logic                   encAPrevQ;
    logic                   encBPrevQ;
    logic                   encA;
    logic                   encB;
    logic                   encPulseQ;
    logic [`SSL_GAP_W-1:0]  gapCntQ;
    logic                   slowQ;
    logic [1:0]             divCntQ;
    logic [1:0]             encCntQ;
    logic                   lockedQ;
    logic [`SSL_LOCK_W-1:0] lockCntQ;
    logic                   lostSet;
    logic                   phaseErr;
    logic                   slowDown;
    logic                   gateOpen;
    ssl_mode_t              modeQ;
    ssl_mode_t              modeD;

    // =====================================================
    // pin synchronisers
    ssl_sync3 #(.WIDTH(`SSL_PIN_W)) u_sync (
        .mclk    (mclk),
        .rst     (rst),
        .pinIn   ({currentDetect, encoderB, encoderA, refSquareWave}),
        .syncOut (pinSync)
    );

    // =====================================================
    // write registers
    // control register write; clear writes act directly on the lost-lock flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrlQ <= `SSL_CTL_RESET;
        end else if (ctrlWrEn) begin
            ctrlQ <= wrData;
        end
    end

    // =====================================================
    // reference pulse generator
    assign refRise = pinSync[`SSL_PIN_REF] & ~refPrevQ;

    always_ff @(posedge mclk) begin
        if (rst) begin
            refPrevQ  <= 1'b0;
            refPulseQ <= 1'b0;
            refGapQ   <= 8'h00;
        end else begin
            refPrevQ  <= pinSync[`SSL_PIN_REF];
            refPulseQ <= refRise || (refGapQ == 8'h01);
            if (refRise) begin
                refGapQ <= 8'(REF_GAP);
            end else if (refGapQ != 8'h00) begin
                refGapQ <= refGapQ - 8'h01;
            end
        end
    end

    // =====================================================
    // encoder pulse generator; software may substitute encoders
    assign encA = ctrlQ[`SSL_CTL_SUBST] ? ctrlQ[`SSL_CTL_SUBST_A] : pinSync[`SSL_PIN_ENC_A];
    assign encB = ctrlQ[`SSL_CTL_SUBST] ? ctrlQ[`SSL_CTL_SUBST_B] : pinSync[`SSL_PIN_ENC_B];

    always_ff @(posedge mclk) begin
        if (rst) begin
            encAPrevQ <= 1'b0;
            encBPrevQ <= 1'b0;
            encPulseQ <= 1'b0;
        end else begin
            encAPrevQ <= encA;
            encBPrevQ <= encB;
            encPulseQ <= (encA != encAPrevQ) || (encB != encBPrevQ);
        end
    end

    // =====================================================
    // gap counter: slow and rotating detection
    // restart on encoder pulse, saturate
    always_ff @(posedge mclk) begin
        if (rst) begin
            gapCntQ <= STOP_CYC;
        end else if (encPulseQ) begin
            gapCntQ <= '0;
        end else if (gapCntQ != STOP_CYC) begin
            gapCntQ <= gapCntQ + `SSL_GAP_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            slowQ        <= 1'b1;
            rotatingFlag <= 1'b0;
        end else begin
            slowQ        <= (gapCntQ > SLOW_CYC);
            rotatingFlag <= (gapCntQ != STOP_CYC);
        end
    end

    // =====================================================
    // divide-by-three limit tick
    // one reference period in three
    always_ff @(posedge mclk) begin
        if (rst) begin
            divCntQ            <= 2'h0;
            thirdRateLimitTick <= 1'b0;
        end else if (refRise) begin
            divCntQ            <= (divCntQ == `SSL_DIV_LAST) ? 2'h0 : divCntQ + 2'h1;
            thirdRateLimitTick <= (divCntQ == `SSL_DIV_LAST);
        end
    end

    // =====================================================
    // phase/frequency detector
    ssl_phase_det u_pfd (
        .mclk     (mclk),
        .rst      (rst),
        .refPulse (refPulseQ),
        .encPulse (encPulseQ),
        .phaseErr (phaseErr),
        .slowDown (slowDown)
    );

    // =====================================================
    // lock, at-speed and lost-lock
    // locked means two encoder pulses per reference period, the locked ratio, while not slow
    always_ff @(posedge mclk) begin
        if (rst) begin
            encCntQ <= 2'h0;
            lockedQ <= 1'b0;
        end else if (refRise) begin
            encCntQ <= {1'b0, encPulseQ};
            lockedQ <= (encCntQ == `SSL_ENC_PER_REF) && !slowQ;
        end else if (encPulseQ && encCntQ != `SSL_ENC_SAT) begin
            encCntQ <= encCntQ + 2'h1;
        end
    end

    // lock must hold for the full interval
    always_ff @(posedge mclk) begin
        if (rst) begin
            lockCntQ <= '0;
        end else if (!lockedQ) begin
            lockCntQ <= '0;
        end else if (lockCntQ != LOCK_CYC) begin
            lockCntQ <= lockCntQ + `SSL_LOCK_W'(1);
        end
    end

    // at-speed low once lock has held
    always_ff @(posedge mclk) begin
        if (rst) begin
            atSpeedN <= 1'b1;
        end else begin
            atSpeedN <= !(lockedQ && lockCntQ == LOCK_CYC);
        end
    end

    assign lostSet = !atSpeedN && !lockedQ;

    // latch on loss, set beats clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            lostLockFlag <= 1'b0;
        end else if (lostSet) begin
            lostLockFlag <= 1'b1;
        end else if (clrWrEn && wrData[`SSL_CLR_LOST]) begin
            lostLockFlag <= 1'b0;
        end
    end

    // =====================================================
    // drive mode and current commands
    // run low brakes while rotating, else idles; enable off coasts
    always_comb begin
        if (ctrlQ[`SSL_CTL_ENABLE_N]) begin
            modeD = SSL_COAST;
        end else if (ctrlQ[`SSL_CTL_RUN]) begin
            modeD = SSL_RUN;
        end else if (rotatingFlag) begin
            modeD = SSL_BRAKE;
        end else begin
            modeD = SSL_IDLE;
        end
    end

    // when slow, limit closes the gate two ticks in three
    assign gateOpen = !(slowQ && !thirdRateLimitTick);

    always_ff @(posedge mclk) begin
        if (rst) begin
            modeQ      <= SSL_COAST;
            dutyLimit  <= 1'b0;
            ampEnableN <= 1'b1;
        end else begin
            modeQ      <= modeD;
            dutyLimit  <= !gateOpen;
            ampEnableN <= !gateOpen || !(modeD == SSL_RUN || modeD == SSL_BRAKE);
        end
    end

    // braking clamps both commands; reverse torque only
    always_ff @(posedge mclk) begin
        if (rst) begin
            currentCmdPos <= `SSL_CMD_ZERO;
            currentCmdNeg <= `SSL_CMD_ZERO;
        end else begin
            case (modeD)
                SSL_RUN: begin
                    currentCmdPos <= (gateOpen && phaseErr) ? `SSL_CMD_FULL : `SSL_CMD_ZERO;
                    currentCmdNeg <= (gateOpen && slowDown) ? `SSL_CMD_FULL : `SSL_CMD_ZERO;
                end
                SSL_BRAKE: begin
                    currentCmdPos <= `SSL_CMD_ZERO;
                    currentCmdNeg <= gateOpen ? `SSL_CMD_BRAKE : `SSL_CMD_ZERO;
                end
                default: begin
                    currentCmdPos <= `SSL_CMD_ZERO;
                    currentCmdNeg <= `SSL_CMD_ZERO;
                end
            endcase
        end
    end

    // =====================================================
    // status registers
    // four readable words
    always_ff @(posedge mclk) begin
        if (rst) begin
            statusReg0 <= 8'h00;
            statusReg1 <= 8'h00;
            statusReg2 <= 8'h00;
            statusReg3 <= 8'h00;
        end else begin
            statusReg0 <= {atSpeedN, lostLockFlag, rotatingFlag, slowQ,
                           phaseErr, thirdRateLimitTick, lockedQ, pinSync[`SSL_PIN_REF]};
            statusReg1 <= {pinSync[`SSL_PIN_CUR_HI:`SSL_PIN_CUR_LO],
                           pinSync[`SSL_PIN_ENC_B], pinSync[`SSL_PIN_ENC_A], encB, encA};
            statusReg2 <= ctrlQ;
            statusReg3 <= {4'h0, ampEnableN, dutyLimit, modeQ};
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_REF_TWO: assert property (refRise |=> refPulseQ ##(REF_GAP) refPulseQ)
        else $error("reference edge did not give two pulses");
    AST_ENC_PULSE: assert property ((encA != encAPrevQ) |=> encPulseQ)
        else $error("encoder change gave no pulse");
    AST_ROTATING: assert property (encPulseQ |=> ##1 rotatingFlag)
        else $error("rotating flag missing after encoder pulse");
    AST_PHASE_READ: assert property (phaseErr |=> statusReg0[3])
        else $error("detector output not readable");
    AST_SLOW: assert property (gapCntQ == SLOW_CYC + 1'b1 |=> slowQ)
        else $error("slow speed not flagged after gap");
    AST_DUTY: assert property (!gateOpen |=> currentCmdPos == 8'h00 && currentCmdNeg == 8'h00
                                             && ampEnableN)
        else $error("drive active while duty limited");
    AST_DIV3: assert property (refRise && divCntQ == 2'h2 |=> thirdRateLimitTick
                                  ##1 (!refRise [*2]) ##0 thirdRateLimitTick)
        else $error("third-rate tick wrong");
    AST_BRAKE: assert property (modeD == SSL_BRAKE |=> currentCmdNeg <= `SSL_CMD_BRAKE
                                   && currentCmdPos == 8'h00)
        else $error("brake current not clamped");
    AST_CLEAR: assert property (clrWrEn && wrData[0] && !lostSet |=> !lostLockFlag)
        else $error("clear write ignored");
    AST_AT_SPEED: assert property ($fell(atSpeedN) |-> $past(lockCntQ) == LOCK_CYC)
        else $error("at-speed before lock interval");
    AST_LOST_HOLD: assert property (lostLockFlag && !clrWrEn |=> lostLockFlag)
        else $error("lost-lock flag dropped without clear");
    COV_SPIN_UP: cover property ($fell(atSpeedN));
    COV_LOST: cover property ($rose(lostLockFlag));
    COV_BRAKE: cover property (modeQ == SSL_BRAKE ##1 modeQ == SSL_IDLE);

endmodule : ssl_speed_lock

// ### tb/ssl_motor_model.sv
// reference clock and hall encoder source standing in for motor and clock pins
module ssl_motor_model #(
    parameter int REF_HALF = 60
) (
    input  wire logic       mclk,
    input  wire logic       encRun,
    input  wire logic [7:0] encHalf,
    output      logic       refSquareWave,
    output      logic       encoderA,
    output      logic       encoderB
);
    timeunit 1ns;
    timeprecision 1ps;

    int   tick  = 0;
    logic nextB = 1'b0;
    logic refQ  = 1'b0;
    logic encAQ = 1'b0;
    logic encBQ = 1'b0;

    assign refSquareWave = refQ;
    assign encoderA      = encAQ;
    assign encoderB      = encBQ;

    // ==========================================
    // shared time base keeps encoder phase fixed
    // pins move on the falling edge, away from the sampling edge
    always @(negedge mclk) begin
        tick <= tick + 1;
        refQ <= (tick / REF_HALF) % 2 == 0;
        // encoder edges while spinning
        // a stopped motor leaves the hall lines where they were
        if (encRun && (tick % encHalf) == (30 % encHalf)) begin
            if (nextB) begin
                encBQ <= ~encBQ;
            end else begin
                encAQ <= ~encAQ;
            end
            nextB <= ~nextB;
        end
    end
endmodule : ssl_motor_model

// ### tb/ssl_speed_lock_tb_top.sv
// self-checking bench for the spindle speed lock control block
module ssl_speed_lock_tb_top import ssl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk          = 1'b0;
    logic       rst           = 1'b1;
    logic       ctrlWrEn      = 1'b0;
    logic       clrWrEn       = 1'b0;
    logic       encRun        = 1'b0;
    logic [7:0] encHalf       = 8'h3c;
    logic [7:0] wrData        = 8'h00;
    logic [3:0] currentDetect = 4'h0;
    logic       refSquareWave, encoderA, encoderB, atSpeedN, rotatingFlag, lostLockFlag;
    logic       thirdRateLimitTick, dutyLimit, ampEnableN;
    logic [7:0] statusReg0, statusReg1, statusReg2, statusReg3, currentCmdPos, currentCmdNeg;
    int         n_fail      = 0;
    int         comparisons = 0;
    int         n, k, cnt;

    initial begin
        forever #2 mclk = ~mclk;
    end

    ssl_motor_model ssl_motor_model_inst (
        .mclk(mclk), .encRun(encRun), .encHalf(encHalf),
        .refSquareWave(refSquareWave), .encoderA(encoderA), .encoderB(encoderB)
    );

    // short counts keep the run brief
    ssl_speed_lock #(
        .SLOW_CYC(25'h0c8), .STOP_CYC(25'h190), .LOCK_CYC(29'h1f4)
    ) ssl_speed_lock_inst (
        .mclk(mclk), .rst(rst), .refSquareWave(refSquareWave),
        .encoderA(encoderA), .encoderB(encoderB), .currentDetect(currentDetect),
        .ctrlWrEn(ctrlWrEn), .clrWrEn(clrWrEn), .wrData(wrData),
        .statusReg0(statusReg0), .statusReg1(statusReg1), .statusReg2(statusReg2),
        .statusReg3(statusReg3), .atSpeedN(atSpeedN), .rotatingFlag(rotatingFlag),
        .lostLockFlag(lostLockFlag), .thirdRateLimitTick(thirdRateLimitTick),
        .dutyLimit(dutyLimit), .ampEnableN(ampEnableN),
        .currentCmdPos(currentCmdPos), .currentCmdNeg(currentCmdNeg)
    );

    // ==========================================
    // access and compare tasks
    task automatic report_and_stop();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic tick_n(input int c);
        repeat (c) @(negedge mclk);
    endtask : tick_n

    // one strobe for a cycle; clr picks the clear register
    task automatic wr(input logic clr, input logic [7:0] d);
        @(negedge mclk);
        wrData   = d;
        ctrlWrEn = ~clr;
        clrWrEn  = clr;
        @(negedge mclk);
        ctrlWrEn = 1'b0;
        clrWrEn  = 1'b0;
    endtask : wr

    task automatic cmp1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: bit got %b want %b", $time, got, exp);
        end
    endtask : cmp1

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: byte got %h want %h", $time, got, exp);
        end
    endtask : cmp8

    function automatic logic pick(input int w);
        case (w)
            0: return rotatingFlag;
            1: return atSpeedN;
            2: return lostLockFlag;
            default: return refSquareWave;
        endcase
    endfunction : pick

    // bounded wait; n holds the cycles spent
    task automatic wait_for(input int w, input logic v, input int bound);
        n = 0;
        while (pick(w) !== v && n < bound) begin
            @(negedge mclk);
            n++;
        end
        if (n >= bound) begin
            n_fail++;
            $display("Error at %0t: wait %0d timed out", $time, w);
            report_and_stop();
        end
    endtask : wait_for

    task automatic mid_ref(input int off);
        wait_for(3, 1'b0, 200);
        wait_for(3, 1'b1, 200);
        tick_n(off);
    endtask : mid_ref

    // ==========================================
    // main sequence
    initial begin
        tick_n(16);
        rst = 1'b0;
        tick_n(4);
        cmp8(statusReg2, 8'h02);
        cmp1(atSpeedN, 1'b1);
        cmp1(lostLockFlag, 1'b0);
        cmp1(rotatingFlag, 1'b0);
        cmp1(ampEnableN, 1'b1);
        cmp8(currentCmdPos, 8'h00);
        cmp8(8'(statusReg3[1:0]), 8'h03);
        for (k = 0; k < 4; k++) begin
            currentDetect = 4'h1 << k;
            tick_n(6);
            cmp8(8'(statusReg1[7:4]), 8'(currentDetect));
        end
        // substituted edges start rotation, silence stops it
        // A returns low so handing back to the idle pins adds no edge
        wr(1'b0, 8'h04);
        wr(1'b0, 8'h0c);
        wait_for(0, 1'b1, 10);
        cmp1(statusReg1[0], 1'b1);
        wr(1'b0, 8'h04);
        wait_for(0, 1'b0, 700);
        cmp1(n > 380, 1'b1);
        wr(1'b0, 8'h01);
        tick_n(3);
        cmp8(statusReg2, 8'h01);
        cmp8(8'(statusReg3[1:0]), 8'h01);
        // motor still: slow, duty limited, detector pinned high
        cnt = 0;
        for (k = 0; k < 9; k++) begin
            mid_ref(30);
            cnt += thirdRateLimitTick;
            cmp1(statusReg0[2], thirdRateLimitTick);
            cmp1(statusReg0[4], 1'b1);
            cmp1(dutyLimit, ~thirdRateLimitTick);
            cmp1(ampEnableN, ~thirdRateLimitTick);
            cmp1(statusReg0[3], 1'b1);
            cmp8(currentCmdPos, thirdRateLimitTick ? 8'hff : 8'h00);
        end
        cmp1(cnt == 3, 1'b1);
        encHalf = 8'h3c;
        encRun  = 1'b1;
        wait_for(0, 1'b1, 200);
        wait_for(1, 1'b0, 3000);
        cmp1(n >= 500, 1'b1);
        tick_n(2);
        cmp1(statusReg0[1], 1'b1);
        cmp1(statusReg0[7], 1'b0);
        cnt = 0;
        repeat (120) begin
            @(negedge mclk);
            cnt += statusReg0[3];
        end
        cmp1(cnt > 0 && cnt < 120, 1'b1);
        encRun = 1'b0;
        wait_for(2, 1'b1, 1000);
        wr(1'b1, 8'h00);
        tick_n(3);
        cmp1(lostLockFlag, 1'b1);
        cmp8(statusReg2, 8'h01);
        wr(1'b1, 8'h01);
        tick_n(3);
        cmp1(lostLockFlag, 1'b0);
        cmp1(atSpeedN, 1'b1);
        // encoder outruns reference
        encHalf = 8'h14;
        encRun  = 1'b1;
        tick_n(300);
        for (k = 0; k < 4; k++) begin
            mid_ref(60);
            cmp1(statusReg0[3], 1'b0);
            cmp8(currentCmdNeg, 8'hff);
        end
        wr(1'b0, 8'h00);
        tick_n(3);
        cmp8(8'(statusReg3[1:0]), 8'h02);
        cmp8(currentCmdNeg, 8'h4c);
        cmp8(currentCmdPos, 8'h00);
        wr(1'b0, 8'h02);
        tick_n(3);
        cmp8(8'(statusReg3[1:0]), 8'h03);
        cmp1(ampEnableN, 1'b1);
        report_and_stop();
    end
endmodule : ssl_speed_lock_tb_top
